// ---- tmc_pkg.sv ----
// Shared constants and types of the two-mode timer/counter channel.
`default_nettype none
package tmc_pkg;

	// ==========================================================
	// Register byte offsets on the bus
	localparam int          ADDR_W      = 5;
	localparam logic [4:0]  OFF_MODE    = 5'h00;
	localparam logic [4:0]  OFF_CTRL    = 5'h04;
	localparam logic [4:0]  OFF_CNT_LO  = 5'h08;
	localparam logic [4:0]  OFF_CNT_HI  = 5'h0c;
	localparam logic [4:0]  OFF_STAT    = 5'h10;
	localparam logic [4:0]  OFF_MASK    = 5'h14;

	// ==========================================================
	// Field positions
	localparam int MODE_LO_BIT  = 0;
	localparam int MODE_HI_BIT  = 1;
	localparam int CSEL_BIT     = 2;
	localparam int GATE_BIT     = 3;
	localparam int HALF_BIT     = 4;
	localparam int EXT_TYPE_BIT = 0;
	localparam int EXT_FLAG_BIT = 1;
	localparam int RUN_BIT      = 4;
	localparam int OVF_BIT      = 5;
	localparam int ST_OVF_BIT   = 0;
	localparam int ST_EXT_BIT   = 1;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_FLAGS = 2'h0;

	// ==========================================================
	// Timing: one state is two clocks, a peripheral cycle six states
	localparam int         CLK_PERIOD_NS     = 100;
	localparam int         CLKS_PER_STATE    = 2;
	localparam int         STATES_PER_PCYCLE = 6;
	localparam int         PCYCLE_CLKS       = CLKS_PER_STATE * STATES_PER_PCYCLE;
	localparam logic [3:0] PHASE_LAST        = 4'(PCYCLE_CLKS - 1);
	localparam logic [3:0] SAMPLE_PHASE      = 4'((5 - 1) * CLKS_PER_STATE + 1);
	localparam logic [3:0] UPDATE_PHASE      = 4'((3 - 1) * CLKS_PER_STATE);

	// ==========================================================
	// Types
	typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RSVD2, MODE_RSVD3} tmc_mode_type;
	typedef enum {BUS_IDLE, BUS_ACK} tmc_bus_state_type;

endpackage
`default_nettype wire

// ---- tmc_sync.sv ----
// Two-flop synchroniser for a group of asynchronous input pins.
`timescale 1ns/100ps
`default_nettype none
module tmc_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] din,
	output var  logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_r;

	// ==========================================================
	// Per-bit stages
	// Reset value is high so an idle pin does not look like a falling edge.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (rst) begin
					meta_r[i] <= 1'b1;
					dout[i]   <= 1'b1;
				end else begin
					meta_r[i] <= din[i];
					dout[i]   <= meta_r[i];
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// ---- tmc_timer.sv ----
// Timer/counter channel in 13-bit and 16-bit modes with an Avalon-MM slave.
// Operation
// - Count is a high byte and low byte in cascade; high overflow sets flag.
// - Setting run starts counting without touching the count bytes.
// - Counter-select clear counts divided clock; set counts count-pin falling edges.
// - Timer operation advances the count by one per peripheral cycle.
// - Baud and clock-out modes advance at system clock divided by two.
// - Count pin sampled once per peripheral cycle; high then low increments.
// - Incremented value appears at the next update state phase.
// - One falling edge takes twelve states; top count rate is clock/24.
// - Mode register bits 0-4 and control bits 0,4 configure the channel; control bits 1,5 are flags.
// - Gate clear: run alone enables; gate and run: gate pin also controls.
// - Rollover from all ones to zeros sets overflow flag and requests interrupt.
// - Mode 0 is 13-bit: five-bit prescaler in low byte feeds high byte.
// - Mode 1 is full 16-bit with bytes in cascade.
// - Overflow flag clears automatically when its interrupt is serviced.
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module tmc_timer
	import tmc_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              SYS_RST,
	input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic              AVS_READ,
	input  wire logic              AVS_WRITE,
	input  wire logic [31:0]       AVS_WRITEDATA,
	input  wire logic [3:0]        AVS_BYTEENABLE,
	output var  logic [31:0]       AVS_READDATA,
	output var  logic              AVS_WAITREQUEST,
	input  wire logic              COUNT_PIN,
	input  wire logic              GATE_INTERRUPT_PIN,
	input  wire logic              INT_ACK,
	output var  logic              OVERFLOW_REQ,
	output var  logic              IRQ
);

	// ==========================================================
	// Declarations
	logic              count_pin_s;
	logic              gate_pin_s;
	tmc_bus_state_type bus_state_r, bus_state_nxt;
	logic              waitreq_r, waitreq_nxt;
	logic [31:0]       rdata_r, rdata_nxt;
	logic [7:0]        timer_mode_register_r, timer_mode_register_nxt;
	logic              ext_interrupt_type_r, ext_interrupt_type_nxt;
	logic              run_bit_r, run_bit_nxt;
	logic [7:0]        count_low_byte_r, count_low_byte_nxt;
	logic [7:0]        count_high_byte_r, count_high_byte_nxt;
	logic [1:0]        status_r, status_nxt;
	logic [1:0]        mask_r, mask_nxt;
	logic              irq_r, irq_nxt;
	logic [3:0]        phase_r, phase_nxt;
	logic              half_r, half_nxt;
	logic              sample_r, sample_nxt;
	logic              pend_r, pend_nxt;
	logic              gate_prev_r, gate_prev_nxt;
	logic              wr_en, sel_counter, gate_bit, enable, tick;
	logic              at_update, at_sample, ovf_set, ext_set;
	logic [16:0]       sum16;
	logic [8:0]        sum_hi;
	tmc_mode_type      mode;

	// ==========================================================
	// Pin synchronisers
	tmc_sync #(.WIDTH(2)) u_sync (
		.clk  (CLK),
		.rst  (SYS_RST),
		.din  ({GATE_INTERRUPT_PIN, COUNT_PIN}),
		.dout ({gate_pin_s, count_pin_s})
	);

	// ==========================================================
	// Decode
	assign mode        = tmc_mode_type'({timer_mode_register_r[MODE_HI_BIT],
		timer_mode_register_r[MODE_LO_BIT]});
	assign sel_counter = timer_mode_register_r[CSEL_BIT];
	assign gate_bit    = timer_mode_register_r[GATE_BIT];
	assign enable      = run_bit_r && (!gate_bit || gate_pin_s);
	assign at_update   = (phase_r == UPDATE_PHASE);
	assign at_sample   = (phase_r == SAMPLE_PHASE);
	assign wr_en       = (bus_state_r == BUS_ACK) && AVS_WRITE && AVS_BYTEENABLE[0];
	assign sum16       = {1'b0, count_high_byte_r, count_low_byte_r} + 17'h00001;
	assign sum_hi      = {1'b0, count_high_byte_r} + 9'h001;

	// ==========================================================
	// Count source and tick
	// Half rate runs off the clock, so it does not wait for the update phase.
	always_comb begin
		phase_nxt = (phase_r == PHASE_LAST) ? 4'h0 : phase_r + 4'h1;
		half_nxt  = !half_r;
		sample_nxt = sample_r;
		pend_nxt   = pend_r;
		if (at_sample) begin
			sample_nxt = count_pin_s;
			if (sample_r && !count_pin_s) begin
				pend_nxt = 1'b1;
			end
		end
		if (at_update && pend_r) begin
			pend_nxt = 1'b0;
		end
		if (sel_counter) begin
			tick = at_update && pend_r;
		end else if (timer_mode_register_r[HALF_BIT]) begin
			tick = half_r;
		end else begin
			tick = at_update;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			phase_r  <= 4'h0;
			half_r   <= 1'b0;
			sample_r <= 1'b1;
			pend_r   <= 1'b0;
		end else begin
			phase_r  <= phase_nxt;
			half_r   <= half_nxt;
			sample_r <= sample_nxt;
			pend_r   <= pend_nxt;
		end
	end

	// ==========================================================
	// Count bytes
	// A bus write to a count byte wins over a same-cycle count of that byte; software stops the channel first.
	always_comb begin
		count_low_byte_nxt  = count_low_byte_r;
		count_high_byte_nxt = count_high_byte_r;
		ovf_set             = 1'b0;
		if (tick && enable) begin
			case (mode)
				MODE_13BIT: begin
					count_low_byte_nxt[4:0] = count_low_byte_r[4:0] + 5'h01;
					if (count_low_byte_r[4:0] == 5'h1f) begin
						count_high_byte_nxt = sum_hi[7:0];
						ovf_set             = sum_hi[8];
					end
				end
				MODE_16BIT: begin
					count_low_byte_nxt  = sum16[7:0];
					count_high_byte_nxt = sum16[15:8];
					ovf_set             = sum16[16];
				end
				default: begin
					count_low_byte_nxt = count_low_byte_r;
				end
			endcase
		end
		if (wr_en && AVS_ADDRESS == OFF_CNT_LO) begin
			count_low_byte_nxt = AVS_WRITEDATA[7:0];
		end
		if (wr_en && AVS_ADDRESS == OFF_CNT_HI) begin
			count_high_byte_nxt = AVS_WRITEDATA[7:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			count_low_byte_r  <= RST_BYTE;
			count_high_byte_r <= RST_BYTE;
		end else begin
			count_low_byte_r  <= count_low_byte_nxt;
			count_high_byte_r <= count_high_byte_nxt;
		end
	end

	// ==========================================================
	// Control, flags and interrupt
	// Level-type external flag re-sets each cycle the pin is low.
	always_comb begin
		timer_mode_register_nxt = timer_mode_register_r;
		ext_interrupt_type_nxt  = ext_interrupt_type_r;
		run_bit_nxt             = run_bit_r;
		mask_nxt                = mask_r;
		status_nxt              = status_r;
		gate_prev_nxt           = gate_pin_s;
		ext_set = ext_interrupt_type_r ? (gate_prev_r && !gate_pin_s) : !gate_pin_s;
		if (wr_en && AVS_ADDRESS == OFF_MODE) begin
			timer_mode_register_nxt = {3'h0, AVS_WRITEDATA[4:0]};
		end
		if (wr_en && AVS_ADDRESS == OFF_CTRL) begin
			ext_interrupt_type_nxt = AVS_WRITEDATA[EXT_TYPE_BIT];
			run_bit_nxt            = AVS_WRITEDATA[RUN_BIT];
		end
		if (wr_en && AVS_ADDRESS == OFF_MASK) begin
			mask_nxt = AVS_WRITEDATA[1:0];
		end
		if (wr_en && AVS_ADDRESS == OFF_STAT) begin
			status_nxt = status_r & ~AVS_WRITEDATA[1:0];
		end
		if (INT_ACK) begin
			status_nxt[ST_OVF_BIT] = 1'b0;
		end
		if (ovf_set) begin
			status_nxt[ST_OVF_BIT] = 1'b1;
		end
		if (ext_set) begin
			status_nxt[ST_EXT_BIT] = 1'b1;
		end
		irq_nxt = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			timer_mode_register_r <= RST_BYTE;
			ext_interrupt_type_r  <= 1'b0;
			run_bit_r             <= 1'b0;
			mask_r                <= RST_FLAGS;
			status_r              <= RST_FLAGS;
			irq_r                 <= 1'b0;
			gate_prev_r           <= 1'b1;
		end else begin
			timer_mode_register_r <= timer_mode_register_nxt;
			ext_interrupt_type_r  <= ext_interrupt_type_nxt;
			run_bit_r             <= run_bit_nxt;
			mask_r                <= mask_nxt;
			status_r              <= status_nxt;
			irq_r                 <= irq_nxt;
			gate_prev_r           <= gate_prev_nxt;
		end
	end

	// ==========================================================
	// Bus slave: one wait cycle, then answer
	always_comb begin
		bus_state_nxt = bus_state_r;
		waitreq_nxt   = 1'b1;
		rdata_nxt     = rdata_r;
		case (bus_state_r)
			BUS_IDLE: begin
				if (AVS_READ || AVS_WRITE) begin
					bus_state_nxt = BUS_ACK;
					waitreq_nxt   = 1'b0;
					rdata_nxt     = 32'h00000000;
					case (AVS_ADDRESS)
						OFF_MODE:   rdata_nxt[7:0] = timer_mode_register_r;
						OFF_CTRL:   rdata_nxt[7:0] = {2'h0, status_r[ST_OVF_BIT], run_bit_r,
							2'h0, status_r[ST_EXT_BIT], ext_interrupt_type_r};
						OFF_CNT_LO: rdata_nxt[7:0] = count_low_byte_r;
						OFF_CNT_HI: rdata_nxt[7:0] = count_high_byte_r;
						OFF_STAT:   rdata_nxt[1:0] = status_r;
						OFF_MASK:   rdata_nxt[1:0] = mask_r;
						default:    rdata_nxt      = 32'h00000000;
					endcase
				end
			end
			BUS_ACK: begin
				bus_state_nxt = BUS_IDLE;
			end
			default: begin
				bus_state_nxt = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			bus_state_r <= BUS_IDLE;
			waitreq_r   <= 1'b1;
			rdata_r     <= 32'h00000000;
		end else begin
			bus_state_r <= bus_state_nxt;
			waitreq_r   <= waitreq_nxt;
			rdata_r     <= rdata_nxt;
		end
	end

	assign AVS_WAITREQUEST = waitreq_r;
	assign AVS_READDATA    = rdata_r;
	assign OVERFLOW_REQ    = status_r[ST_OVF_BIT];
	assign IRQ             = irq_r;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_request;
		(bus_state_r == BUS_IDLE) && (AVS_READ || AVS_WRITE);
	endsequence
	sequence s_edge_seen;
		at_sample && sample_r && !count_pin_s;
	endsequence

	property p_answer;
		s_request |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer not one cycle");

	property p_hold_when_off;
		(!enable && !wr_en) |=> $stable({count_high_byte_r, count_low_byte_r});
	endproperty
	a_hold_when_off: assert property (p_hold_when_off) else $error("count moved while off");

	property p_timer_step;
		(enable && !sel_counter && !timer_mode_register_r[HALF_BIT] && mode == MODE_16BIT
			&& at_update && !wr_en)
			|=> {count_high_byte_r, count_low_byte_r}
			== $past({count_high_byte_r, count_low_byte_r}) + 16'h0001;
	endproperty
	a_timer_step: assert property (p_timer_step) else $error("timer did not add one");

	property p_overflow;
		(tick && enable && mode == MODE_16BIT && !wr_en
			&& {count_high_byte_r, count_low_byte_r} == 16'hffff)
			|=> OVERFLOW_REQ && (IRQ || !mask_r[ST_OVF_BIT]);
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow flag not set");

	property p_prescale;
		(mode == MODE_13BIT && count_low_byte_r[4:0] != 5'h1f && !wr_en)
			|=> $stable(count_high_byte_r);
	endproperty
	a_prescale: assert property (p_prescale) else $error("high byte moved early");

	property p_edge_to_count;
		s_edge_seen ##1 (!at_update)[*2] |=> pend_r;
	endproperty
	a_edge_to_count: assert property (p_edge_to_count) else $error("edge lost");

	property p_update;
		(sel_counter && pend_r && at_update && enable && !wr_en && mode == MODE_16BIT)
			|=> count_low_byte_r != $past(count_low_byte_r) ##1 !pend_r;
	endproperty
	a_update: assert property (p_update) else $error("count not updated");

	property p_service;
		(INT_ACK && !ovf_set) |=> !OVERFLOW_REQ;
	endproperty
	a_service: assert property (p_service) else $error("flag not cleared on service");

	property p_irq;
		IRQ == |(status_r & mask_r);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");

endmodule
`default_nettype wire

// ---- tmc_pin_model.sv ----
// Pin-level model of the external count source and the gate interrupt source.
`timescale 1ns/100ps
`default_nettype none
module tmc_pin_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       pulse_go,
	input  wire logic       gate_go,
	input  wire logic [7:0] hold_clks,
	output var  logic       count_pin,
	output var  logic       gate_pin,
	output var  logic       busy
);
	// ==========================================================
	// Pattern sequencer
	// Both pins idle high, as pins with pull-ups would, so no edge is seen between patterns.
	logic [1:0]  kind_r;
	logic [1:0]  kind_nxt;
	logic [9:0]  cnt_r;
	logic [9:0]  cnt_nxt;
	logic [7:0]  len_r;
	logic [7:0]  len_nxt;
	logic [9:0]  total;

	always_comb begin
		kind_nxt = kind_r;
		cnt_nxt  = cnt_r + 10'h001;
		len_nxt  = len_r;
		total    = (kind_r == 2'h1) ? {1'b0, len_r, 1'b0} : 10'(len_r) * 10'h003;
		if (kind_r == 2'h0) begin
			cnt_nxt = 10'h000;
			len_nxt = hold_clks;
			if (pulse_go) begin
				kind_nxt = 2'h1;
			end else if (gate_go) begin
				kind_nxt = 2'h2;
			end
		end else if (cnt_nxt == total) begin
			kind_nxt = 2'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			kind_r <= 2'h0;
			cnt_r  <= 10'h000;
			len_r  <= 8'h00;
		end else begin
			kind_r <= kind_nxt;
			cnt_r  <= cnt_nxt;
			len_r  <= len_nxt;
		end
	end

	// Each level is held for hold_clks, so one falling edge per two holds at most.
	assign count_pin = !(kind_r == 2'h1 && cnt_r < 10'(len_r));
	// Low, then high for exactly one hold, then low again: the high window is exact.
	assign gate_pin  = !(kind_r == 2'h2 && (cnt_r < 10'(len_r) || cnt_r >= {1'b0, len_r, 1'b0}));
	assign busy      = (kind_r != 2'h0);
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench of the timer/counter channel with its pin model.
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import tmc_pkg::*;
;
	logic              clk;
	logic              sys_rst;
	logic [ADDR_W-1:0] avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [31:0]       avs_writedata;
	logic [3:0]        avs_byteenable;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	logic              count_pin;
	logic              gate_pin;
	logic              int_ack;
	logic              overflow_req;
	logic              irq;
	logic              pulse_go;
	logic              gate_go;
	logic [7:0]        hold_clks;
	logic              pin_busy;
	logic [31:0]       rdata;
	int                failures;
	int                check_count;

	tmc_timer tmc_timer_i (.CLK(clk), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
		.AVS_WAITREQUEST(avs_waitrequest), .COUNT_PIN(count_pin),
		.GATE_INTERRUPT_PIN(gate_pin), .INT_ACK(int_ack), .OVERFLOW_REQ(overflow_req),
		.IRQ(irq));

	tmc_pin_model tmc_pin_model_i (.clk(clk), .rst(sys_rst), .pulse_go(pulse_go),
		.gate_go(gate_go), .hold_clks(hold_clks), .count_pin(count_pin),
		.gate_pin(gate_pin), .busy(pin_busy));

	always #50 clk = ~clk;

	// ==========================================================
	// Shared tasks
	task automatic close_out();
		$display("checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// A dead cycle first, so a release and the next request never share a time step.
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] addr, input logic [7:0] data);
		int i;
		@(posedge clk);
		avs_address   <= addr;
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= {24'h000000, data};
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0) break;
		end
		rdata = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (i == 20) begin
			failures++;
			close_out();
		end
	endtask

	task automatic wait_idle();
		int i;
		for (i = 0; i < 400; i++) begin
			@(posedge clk);
			if (pin_busy === 1'b0) break;
		end
		if (i == 400) begin
			failures++;
			close_out();
		end
	endtask

	task automatic wait_ovf(input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(posedge clk);
			if (overflow_req === 1'b1) break;
		end
		if (i == lim) begin
			failures++;
			close_out();
		end
	endtask

	task automatic pulse(input logic [7:0] len);
		hold_clks <= len;
		pulse_go  <= 1'b1;
		@(posedge clk);
		pulse_go <= 1'b0;
		wait_idle();
	endtask

	// Counts only inside an exact high window of the gate pin, so the increment is exact.
	task automatic run_gated(input logic [7:0] mode, input logic [7:0] ctrl,
		input logic [7:0] len, input logic [7:0] inc);
		bus(1'b1, OFF_CTRL, 8'h00);
		bus(1'b1, OFF_MODE, mode);
		bus(1'b1, OFF_CNT_LO, 8'h10);
		bus(1'b1, OFF_CNT_HI, 8'h02);
		hold_clks <= len;
		gate_go   <= 1'b1;
		@(posedge clk);
		gate_go <= 1'b0;
		tick(4);
		bus(1'b1, OFF_CTRL, ctrl);
		bus(1'b0, OFF_CNT_LO, 8'h00);
		check("count with gate low", rdata, 32'h10);
		tick(int'(len) * 5 / 2 - 13);
		bus(1'b0, OFF_CNT_LO, 8'h00);
		check("count after window", rdata, {24'h0, 8'h10 + inc});
		bus(1'b0, OFF_STAT, 8'h00);
		check("ext flag", {31'h0, rdata[ST_EXT_BIT]}, 32'h1);
		bus(1'b0, OFF_CTRL, 8'h00);
		check("control readback", rdata, {24'h0, ctrl | 8'h02});
		bus(1'b1, OFF_CTRL, 8'h00);
		wait_idle();
		tick(4);
		bus(1'b1, OFF_STAT, 8'h02);
		bus(1'b0, OFF_STAT, 8'h00);
		check("status cleared", rdata, 32'h0);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		logic [ADDR_W-1:0] offs [7] = '{OFF_MODE, OFF_CTRL, OFF_CNT_LO, OFF_CNT_HI, OFF_STAT,
			OFF_MASK, 5'h18};
		int                k;
		bus(1'b1, 5'h18, 8'hff);
		for (k = 0; k < 7; k++) begin
			bus(1'b0, offs[k], 8'h00);
			check("reset register", rdata, 32'h0);
		end
		check("reset irq", {31'h0, irq}, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_gated_timer();
		run_gated(8'h09, 8'h10, 8'd120, 8'd10);
		$display("test gated timer done");
	endtask

	task automatic t_half_rate();
		run_gated(8'h19, 8'h11, 8'd24, 8'd12);
		$display("test half rate done");
	endtask

	task automatic t_overflow();
		bus(1'b1, OFF_MODE, 8'h01);
		bus(1'b1, OFF_CNT_LO, 8'hff);
		bus(1'b1, OFF_CNT_HI, 8'hff);
		bus(1'b1, OFF_CTRL, 8'h10);
		wait_ovf(30);
		check("masked irq", {31'h0, irq}, 32'h0);
		bus(1'b0, OFF_CNT_LO, 8'h00);
		check("low after rollover", rdata, 32'h0);
		bus(1'b0, OFF_CNT_HI, 8'h00);
		check("high after rollover", rdata, 32'h0);
		bus(1'b0, OFF_CTRL, 8'h00);
		check("control flags", rdata, 32'h30);
		bus(1'b1, OFF_MASK, 8'h01);
		tick(2);
		check("unmasked irq", {31'h0, irq}, 32'h1);
		int_ack <= 1'b1;
		@(posedge clk);
		int_ack <= 1'b0;
		tick(2);
		check("flag after service", {30'h0, overflow_req, irq}, 32'h0);
		bus(1'b1, OFF_CTRL, 8'h00);
		$display("test overflow done");
	endtask

	task automatic t_mode0();
		bus(1'b1, OFF_MODE, 8'h00);
		bus(1'b1, OFF_CNT_LO, 8'h1f);
		bus(1'b1, OFF_CNT_HI, 8'hff);
		bus(1'b1, OFF_CTRL, 8'h10);
		wait_ovf(30);
		bus(1'b0, OFF_CNT_HI, 8'h00);
		check("13-bit high", rdata, 32'h0);
		bus(1'b0, OFF_CNT_LO, 8'h00);
		check("13-bit prescaler", {27'h0, rdata[4:0]}, 32'h0);
		check("irq on overflow", {31'h0, irq}, 32'h1);
		bus(1'b1, OFF_STAT, 8'h01);
		tick(2);
		check("flag after clear", {30'h0, overflow_req, irq}, 32'h0);
		bus(1'b1, OFF_CTRL, 8'h00);
		$display("test mode 0 done");
	endtask

	task automatic t_counter();
		bus(1'b1, OFF_MODE, 8'h05);
		bus(1'b1, OFF_CNT_LO, 8'h00);
		bus(1'b1, OFF_CNT_HI, 8'h00);
		bus(1'b1, OFF_CTRL, 8'h10);
		pulse(8'd12);
		pulse(8'd12);
		pulse(8'd30);
		tick(30);
		bus(1'b1, OFF_CTRL, 8'h00);
		bus(1'b0, OFF_CNT_LO, 8'h00);
		check("edges counted", rdata, 32'h3);
		bus(1'b0, OFF_CNT_HI, 8'h00);
		check("edge count high", rdata, 32'h0);
		$display("test counter done");
	endtask

	// Reserved mode must hold its count; a write without lane 0 must be ignored.
	task automatic t_reserved();
		bus(1'b1, OFF_MODE, 8'h02);
		bus(1'b1, OFF_CNT_LO, 8'h55);
		avs_byteenable <= 4'h0;
		bus(1'b1, OFF_CNT_LO, 8'haa);
		avs_byteenable <= 4'h1;
		bus(1'b1, OFF_CTRL, 8'h10);
		tick(30);
		bus(1'b0, OFF_CNT_LO, 8'h00);
		check("reserved mode count", rdata, 32'h55);
		bus(1'b1, OFF_CTRL, 8'h00);
		$display("test reserved mode done");
	endtask

	initial begin
		clk            = 1'b0;
		sys_rst        = 1'b1;
		avs_address    = '0;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0;
		avs_byteenable = 4'h1;
		int_ack        = 1'b0;
		pulse_go       = 1'b0;
		gate_go        = 1'b0;
		hold_clks      = 8'h0c;
		failures       = 0;
		check_count    = 0;
		tick(2);
		sys_rst <= 1'b0;
		t_reset();
		t_gated_timer();
		t_half_rate();
		t_overflow();
		t_mode0();
		t_counter();
		t_reserved();
		close_out();
	end
endmodule
`default_nettype wire
